// ---- core/current_detect.v ----
// one current detector: qualify timer, 90% drop-out, minimum on width
// assumes level already clamped; level of zero disables the detector
`timescale 1ns/1ns
`include "speed_current_consts.vh"
module current_detect #(
  parameter CW     = 16,
  parameter TW     = 20,
  parameter MIN_ON = 100
) (
  input  wire          sys_clk,    // system clock
  input  wire          srst,       // sync reset
  input  wire          ce,         // clock enable
  input  wire          smp,        // control sample strobe
  input  wire [CW-1:0] cur,        // output current
  input  wire [CW-1:0] level,      // operating level, 0 disables
  input  wire [TW-1:0] det_smp,    // detection time in samples
  output reg           det_flag    // current detected
);

  localparam [CW+3:0] DROP_DEN = `CUR_DROP_DEN;
  localparam [CW+3:0] DROP_NUM = `CUR_DROP_NUM;
  localparam [TW-1:0] MIN_ON_W = MIN_ON;

  reg  [TW-1:0] qual_reg;
  reg  [TW-1:0] on_reg;
  wire          above = (cur > level);
  wire [CW+3:0] cur_x = {4'h0, cur} * DROP_DEN;
  wire [CW+3:0] lvl_x = {4'h0, level} * DROP_NUM;
  wire          drop  = (cur_x < lvl_x);

  always @(posedge sys_clk) begin
    if (srst) begin
      qual_reg <= {TW{1'b0}};
      on_reg   <= {TW{1'b0}};
      det_flag <= 1'b0;
    end else if (ce && smp) begin
      if (level == {CW{1'b0}}) begin
        qual_reg <= {TW{1'b0}};
        on_reg   <= {TW{1'b0}};
        det_flag <= 1'b0;
      end else if (!det_flag) begin
        on_reg <= {TW{1'b0}};
        if (!above) begin
          qual_reg <= {TW{1'b0}};
        end else if (qual_reg >= det_smp) begin
          det_flag <= 1'b1;
        end else begin
          qual_reg <= qual_reg + 1'b1;
        end
      end else begin
        qual_reg <= {TW{1'b0}};
        if (on_reg < MIN_ON_W) begin
          on_reg <= on_reg + 1'b1;
        end
        if (drop && (on_reg >= MIN_ON_W - 1'b1)) begin
          det_flag <= 1'b0;
        end
      end
    end
  end

endmodule // current_detect

// ---- core/off_delay.v ----
// on-to-off delay: output follows a rise at once, falls after delay samples
// assumes smp is a one-cycle control sample strobe
`timescale 1ns/1ns
module off_delay #(
  parameter DW = 20
) (
  input  wire          sys_clk,    // system clock
  input  wire          srst,       // sync reset
  input  wire          ce,         // clock enable
  input  wire          smp,        // control sample strobe
  input  wire          in_flag,    // undelayed flag
  input  wire [DW-1:0] delay_smp,  // off delay in samples
  output reg           out_flag    // delayed flag
);

  reg [DW-1:0] cnt_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg  <= {DW{1'b0}};
      out_flag <= 1'b0;
    end else if (ce && smp) begin
      if (in_flag) begin
        cnt_reg  <= {DW{1'b0}};
        out_flag <= 1'b1;
      end else if (out_flag) begin
        if (cnt_reg >= delay_smp) begin
          out_flag <= 1'b0;
          cnt_reg  <= {DW{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule // off_delay

// ---- core/speed_current_consts.vh ----
// constants for the speed and current detect output block
// assumes speeds in 0.01 r/min, currents in 0.01 A, times in 0.01 s
`ifndef SPEED_CURRENT_CONSTS_VH
`define SPEED_CURRENT_CONSTS_VH

// output terminal selection codes
`define SEL_SPEED_ARRIVAL    8'h01
`define SEL_SPEED_THRESH_1   8'h02
`define SEL_SPEED_THRESH_2   8'h1f
`define SEL_CURRENT_DET_1    8'h25
`define SEL_CURRENT_DET_2    8'h26
`define SEL_ARRIVAL_NORUN    8'h48
`define SEL_ACCELERATING     8'h49
`define SEL_DECELERATING     8'h4a

// setting limits, 0.01 r/min
`define ARRIVAL_HYST_MAX     20'd600000
`define SPEED_LEVEL_MAX      20'd600000
`define THRESH_HYST_MAX      20'd90000

// current detect time limits, 0.01 s
`define DET_TIME_MIN         16'd1
`define DET_TIME_MAX         16'd60000

// current level range, as a multiple (max) and divisor (min) of rated current
`define CUR_LEVEL_MAX_PCT    2
`define CUR_LEVEL_MIN_DIV    100
`define CUR_DROP_NUM         9
`define CUR_DROP_DEN         10

// direction level upper limit, percent
`define DIR_LEVEL_MAX        7'd100

// timing: one control sample, and time units in microseconds
`define SAMPLE_PERIOD_US     1000
`define CSEC_US              10000
`define MIN_ON_TIME_US       100000

`endif

// ---- core/speed_current_detect_outputs.v ----
// speed arrival, acceleration, speed threshold and current detect flags,
// routed to programmable output terminals by selection codes
// assumes all inputs synchronous to sys_clk and smp one cycle per sample
`timescale 1ns/1ns
`include "speed_current_consts.vh"
module speed_current_detect_outputs #(
  parameter SPW   = 21,
  parameter CW    = 16,
  parameter NTERM = 6
) (
  input  wire                  sys_clk,                      // 20 MHz clock
  input  wire                  srst,                         // sync reset
  input  wire                  ce,                           // clock enable
  input  wire                  smp,                          // control sample
  input  wire                  run_cmd,                      // run command
  input  wire                  tvc_mode,                     // torque vector ctrl
  input  wire signed [SPW-1:0] ref_speed_pre,                // pre-ramp ref
  input  wire signed [SPW-1:0] ref_speed_final,              // post-ramp ref
  input  wire signed [SPW-1:0] det_speed,                    // detected speed
  input  wire                  speed_agree_raw,              // agreement in
  input  wire [CW-1:0]         out_current,                  // 0.01 A
  input  wire [CW-1:0]         rated_current,                // 0.01 A
  input  wire signed [8:0]     torque_cmd,                   // percent
  input  wire                  direction_judge,              // judge strobe
  input  wire [SPW-2:0]        arrival_hysteresis_setting,   // 0.01 r/min
  input  wire [15:0]           arrival_off_delay_setting,    // 0.01 s
  input  wire [SPW-2:0]        speed_level_1_setting,        // 0.01 r/min
  input  wire [SPW-2:0]        speed_level_2_setting,        // 0.01 r/min
  input  wire [SPW-2:0]        threshold_hysteresis_setting, // 0.01 r/min
  input  wire [CW-1:0]         current_level_1_setting,      // 0.01 A
  input  wire [CW-1:0]         current_level_2_setting,      // 0.01 A
  input  wire [15:0]           current_detect_time_setting,  // 0.01 s
  input  wire [6:0]            direction_level_setting,      // percent
  input  wire [7:0]            protection_options_setting,   // option bits
  input  wire [NTERM*8-1:0]    output_terminal_select,       // codes
  output reg  [NTERM-1:0]      term_out,                     // terminals
  output reg                   speed_arrival_flag,           // arrival
  output reg                   speed_arrival_norun_flag,     // arrival no run
  output reg                   accelerating_flag,            // accelerating
  output reg                   decelerating_flag,            // decelerating
  output reg                   speed_agreement_flag,         // agreement
  output reg                   speed_threshold_flag_1,       // threshold 1
  output reg                   speed_threshold_flag_2,       // threshold 2
  output reg                   current_detect_flag_1,        // current 1
  output reg                   current_detect_flag_2,        // current 2
  output reg                   over_torque_detect,           // over-torque
  output reg                   recommended_direction_out     // 1 = forward
);

  localparam          TW       = 20;
  localparam [TW-1:0] SPC      = `CSEC_US / `SAMPLE_PERIOD_US;
  localparam          MIN_ON   = (`MIN_ON_TIME_US + `SAMPLE_PERIOD_US - 1) / `SAMPLE_PERIOD_US;
  localparam [CW:0]   CUR_MULT = `CUR_LEVEL_MAX_PCT;
  localparam [CW-1:0] CUR_DIV  = `CUR_LEVEL_MIN_DIV;

  // setting clamps
  wire [SPW-2:0] arr_hyst;
  wire [SPW-2:0] lvl_1;
  wire [SPW-2:0] lvl_2;
  wire [SPW-2:0] thr_hyst;
  wire [15:0]    det_time;
  wire [CW:0]    cur_max;
  wire [CW-1:0]  cur_min;
  wire [CW-1:0]  cur_lvl_1;
  wire [CW-1:0]  cur_lvl_2;
  wire [6:0]     dir_lvl;

  assign arr_hyst = (arrival_hysteresis_setting > `ARRIVAL_HYST_MAX) ?
                    `ARRIVAL_HYST_MAX : arrival_hysteresis_setting;
  assign lvl_1    = (speed_level_1_setting > `SPEED_LEVEL_MAX) ?
                    `SPEED_LEVEL_MAX : speed_level_1_setting;
  assign lvl_2    = (speed_level_2_setting > `SPEED_LEVEL_MAX) ?
                    `SPEED_LEVEL_MAX : speed_level_2_setting;
  assign thr_hyst = (threshold_hysteresis_setting > `THRESH_HYST_MAX) ?
                    `THRESH_HYST_MAX : threshold_hysteresis_setting;
  assign det_time = (current_detect_time_setting < `DET_TIME_MIN) ? `DET_TIME_MIN :
                    (current_detect_time_setting > `DET_TIME_MAX) ? `DET_TIME_MAX :
                    current_detect_time_setting;
  assign cur_max = {1'b0, rated_current} * CUR_MULT;
  assign cur_min = rated_current / CUR_DIV;

  function [CW-1:0] cur_clamp;
    input [CW-1:0] lvl;
    input [CW:0]   hi;
    input [CW-1:0] lo;
    begin
      if (lvl == {CW{1'b0}}) begin
        cur_clamp = {CW{1'b0}};
      end else if ({1'b0, lvl} > hi) begin
        cur_clamp = hi[CW-1:0];
      end else if (lvl < lo) begin
        cur_clamp = lo;
      end else begin
        cur_clamp = lvl;
      end
    end
  endfunction

  assign cur_lvl_1 = cur_clamp(current_level_1_setting, cur_max, cur_min);
  assign cur_lvl_2 = cur_clamp(current_level_2_setting, cur_max, cur_min);
  assign dir_lvl   = (direction_level_setting > `DIR_LEVEL_MAX) ?
                     `DIR_LEVEL_MAX : direction_level_setting;

  // times in samples
  wire [TW-1:0] off_smp = {4'h0, arrival_off_delay_setting} * SPC;
  wire [TW-1:0] det_smp = {4'h0, det_time} * SPC;

  // speed comparisons
  wire signed [SPW-1:0] cmp_speed;
  wire signed [SPW:0]   diff;
  wire signed [SPW:0]   hyst_s;
  wire                  in_range;

  // final reference under torque vector control
  assign cmp_speed = tvc_mode ? ref_speed_final : det_speed;
  assign diff      = {ref_speed_pre[SPW-1], ref_speed_pre} -
                     {cmp_speed[SPW-1], cmp_speed};
  assign hyst_s    = {2'b00, arr_hyst};
  assign in_range  = (diff <= hyst_s) && (diff >= -hyst_s);

  // raw flags, refreshed once per sample
  reg arr_raw_reg;
  reg acc_raw_reg;
  reg dec_raw_reg;

  always @(posedge sys_clk) begin
    if (srst) begin
      arr_raw_reg <= 1'b0;
      acc_raw_reg <= 1'b0;
      dec_raw_reg <= 1'b0;
    end else if (ce && smp) begin
      arr_raw_reg <= in_range;
      acc_raw_reg <= (diff > hyst_s);
      dec_raw_reg <= (diff < -hyst_s);
    end
  end

  wire arr_dly;
  wire acc_dly;
  wire dec_dly;
  wire agr_dly;

  off_delay #(.DW(TW)) u_dly_arr (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .ce        (ce),
    .smp       (smp),
    .in_flag   (arr_raw_reg),
    .delay_smp (off_smp),
    .out_flag  (arr_dly)
  );
  off_delay #(.DW(TW)) u_dly_acc (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .ce        (ce),
    .smp       (smp),
    .in_flag   (acc_raw_reg),
    .delay_smp (off_smp),
    .out_flag  (acc_dly)
  );
  off_delay #(.DW(TW)) u_dly_dec (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .ce        (ce),
    .smp       (smp),
    .in_flag   (dec_raw_reg),
    .delay_smp (off_smp),
    .out_flag  (dec_dly)
  );
  off_delay #(.DW(TW)) u_dly_agr (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .ce        (ce),
    .smp       (smp),
    .in_flag   (speed_agree_raw),
    .delay_smp (off_smp),
    .out_flag  (agr_dly)
  );

  // speed thresholds with hysteresis
  wire [SPW*2-3:0] lvl_pack = {lvl_2, lvl_1};
  wire [1:0]       thr_state;
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_thr
      wire signed [SPW:0] lvl_s = {2'b00, lvl_pack[t*(SPW-1) +: SPW-1]};
      wire signed [SPW:0] low_s = lvl_s - {2'b00, thr_hyst};
      wire signed [SPW:0] spd_s = {cmp_speed[SPW-1], cmp_speed};
      reg                 thr_bit_reg;
      assign thr_state[t] = thr_bit_reg;
      always @(posedge sys_clk) begin
        if (srst) begin
          thr_bit_reg <= 1'b0;
        end else if (ce && smp) begin
          if (spd_s > lvl_s) begin
            thr_bit_reg <= 1'b1;
          end else if (spd_s < low_s) begin
            thr_bit_reg <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // current detectors
  wire cd_1;
  wire cd_2;

  current_detect #(.CW(CW), .TW(TW), .MIN_ON(MIN_ON)) u_cd_1 (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .ce       (ce),
    .smp      (smp),
    .cur      (out_current),
    .level    (cur_lvl_1),
    .det_smp  (det_smp),
    .det_flag (cd_1)
  );
  current_detect #(.CW(CW), .TW(TW), .MIN_ON(MIN_ON)) u_cd_2 (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .ce       (ce),
    .smp      (smp),
    .cur      (out_current),
    .level    (cur_lvl_2),
    .det_smp  (det_smp),
    .det_flag (cd_2)
  );

  // recommended direction and flag outputs
  wire signed [8:0] lvl_dir = {2'b00, dir_lvl};
  wire              ot_sel  = protection_options_setting[0];
  wire              ref_neg = ref_speed_pre[SPW-1];
  wire [NTERM-1:0]  term_next;

  always @(posedge sys_clk) begin
    if (srst) begin
      speed_arrival_flag        <= 1'b0;
      speed_arrival_norun_flag  <= 1'b0;
      accelerating_flag         <= 1'b0;
      decelerating_flag         <= 1'b0;
      speed_agreement_flag      <= 1'b0;
      speed_threshold_flag_1    <= 1'b0;
      speed_threshold_flag_2    <= 1'b0;
      current_detect_flag_1     <= 1'b0;
      current_detect_flag_2     <= 1'b0;
      over_torque_detect        <= 1'b0;
      recommended_direction_out <= 1'b0;
      term_out                  <= {NTERM{1'b0}};
    end else if (ce) begin
      // arrival flag gated by run and reference sign, current flag 1 split by the over-torque option, other flags passed straight through
      speed_arrival_flag       <= arr_dly & run_cmd & ~ref_neg;
      speed_arrival_norun_flag <= arr_raw_reg;
      accelerating_flag        <= acc_dly;
      decelerating_flag        <= dec_dly;
      speed_agreement_flag     <= agr_dly;
      speed_threshold_flag_1   <= thr_state[0];
      speed_threshold_flag_2   <= thr_state[1];
      term_out                 <= term_next;
      current_detect_flag_1    <= cd_1 & ~ot_sel;
      over_torque_detect       <= cd_1 & ot_sel;
      current_detect_flag_2    <= cd_2;
      if (smp && direction_judge) begin
        if (torque_cmd > lvl_dir) begin
          recommended_direction_out <= 1'b0;
        end else if (torque_cmd < -lvl_dir) begin
          recommended_direction_out <= 1'b1;
        end
      end
    end
  end

  // terminal routing, one entry per terminal
  genvar k;
  generate
    for (k = 0; k < NTERM; k = k + 1) begin : g_term
      wire [7:0] code = output_terminal_select[k*8 +: 8];
      reg        sel_next;
      always @* begin
        case (code)
          `SEL_SPEED_ARRIVAL:  sel_next = speed_arrival_flag;
          `SEL_SPEED_THRESH_1: sel_next = speed_threshold_flag_1;
          `SEL_SPEED_THRESH_2: sel_next = speed_threshold_flag_2;
          `SEL_CURRENT_DET_1:  sel_next = current_detect_flag_1;
          `SEL_CURRENT_DET_2:  sel_next = current_detect_flag_2;
          `SEL_ARRIVAL_NORUN:  sel_next = speed_arrival_norun_flag;
          `SEL_ACCELERATING:   sel_next = accelerating_flag;
          `SEL_DECELERATING:   sel_next = decelerating_flag;
          default:             sel_next = 1'b0;
        endcase
      end
      assign term_next[k] = sel_next;
    end
  endgenerate

endmodule // speed_current_detect_outputs

// ---- verif/lift_ctrl_model.sv ----
// lift controller model: latches every output terminal seen on
// assumes term_out is registered on sys_clk
`timescale 1ns/1ns
module lift_ctrl_model #(
  parameter NTERM = 6
) (
  input logic             sys_clk,   // system clock
  input logic             clr,       // clears the seen record
  input logic [NTERM-1:0] term_out,  // drive terminals
  output logic [NTERM-1:0] term_seen // terminals seen on
);
  always @(posedge sys_clk) begin
    term_seen <= clr ? '0 : (term_seen | term_out);
  end
endmodule // lift_ctrl_model

// ---- verif/speed_current_detect_outputs_chk.sv ----
// checker for the speed and current detect output block
// assumes bound to the design top, settings steady between samples
`timescale 1ns/1ns
module speed_current_detect_outputs_chk #(
  parameter SPW = 21,
  parameter CW = 16,
  parameter NTERM = 6
) (
  input logic sys_clk, srst, ce, smp, tvc_mode, speed_agree_raw,
  input logic signed [SPW-1:0] ref_speed_pre, ref_speed_final, det_speed,
  input logic [CW-1:0] out_current, rated_current, current_level_1_setting,
  input logic [SPW-2:0] arrival_hysteresis_setting, speed_level_1_setting,
  input logic [SPW-2:0] threshold_hysteresis_setting,
  input logic [15:0] current_detect_time_setting,
  input logic [7:0] protection_options_setting,
  input logic [NTERM*8-1:0] output_terminal_select,
  input logic [NTERM-1:0] term_out,
  input logic speed_arrival_flag, speed_arrival_norun_flag, accelerating_flag,
  input logic decelerating_flag, speed_agreement_flag, speed_threshold_flag_1,
  input logic speed_threshold_flag_2, current_detect_flag_1, current_detect_flag_2,
  input logic over_torque_detect
);
  logic signed [SPW+1:0] cmp, diff, hyst, thr_hi, thr_lo;
  logic [CW:0] lvl, cmin, cmax;
  logic [15:0] tq;
  logic [23:0] det_need, above_cnt, on_cnt;
  logic [7:0] good_cnt, flg;
  assign flg = {current_detect_flag_2, current_detect_flag_1, speed_threshold_flag_2,
                speed_threshold_flag_1, decelerating_flag, accelerating_flag,
                speed_arrival_norun_flag, speed_arrival_flag};
  always_comb begin
    cmp = tvc_mode ? ref_speed_final : det_speed;
    diff = ref_speed_pre - cmp;
    hyst = (arrival_hysteresis_setting > 20'h927c0) ? 22'sh927c0 : arrival_hysteresis_setting;
    thr_hi = (speed_level_1_setting > 20'h927c0) ? 22'sh927c0 : speed_level_1_setting;
    thr_lo = thr_hi - ((threshold_hysteresis_setting > 20'h15f90) ? 22'sh15f90
             : threshold_hysteresis_setting);
    cmin = rated_current / 100;
    cmax = {rated_current, 1'b0};
    lvl = current_level_1_setting;
    if (lvl != 0 && lvl < cmin) lvl = cmin;
    if (lvl > cmax) lvl = cmax;
    tq = current_detect_time_setting;
    if (tq < 16'h1) tq = 16'h1;
    if (tq > 16'hea60) tq = 16'hea60;
    det_need = tq * 10 + 1;
  end
  always_ff @(posedge sys_clk) begin
    good_cnt <= (srst || !ce || !smp) ? 8'h00 : good_cnt + {7'h0, good_cnt != 8'hff};
    if (srst) above_cnt <= '0;
    else if (ce && smp) above_cnt <= (lvl != 0 && out_current > lvl) ? above_cnt + 1 : '0;
    if (srst || !current_detect_flag_1) on_cnt <= '0;
    else if (ce && smp) on_cnt <= on_cnt + 1;
  end
  function automatic logic term_want(input logic [7:0] c, input logic [7:0] f);
    case (c)
      8'h01: term_want = f[0];
      8'h48: term_want = f[1];
      8'h49: term_want = f[2];
      8'h4a: term_want = f[3];
      8'h02: term_want = f[4];
      8'h1f: term_want = f[5];
      8'h25: term_want = f[6];
      8'h26: term_want = f[7];
      default: term_want = 1'b0;
    endcase
  endfunction
  sequence two_good;
    good_cnt >= 8'h02;
  endsequence
  sequence three_good;
    good_cnt >= 8'h03;
  endsequence
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  for (genvar k = 0; k < NTERM; k++) begin : g_term
    term_route_a: assert property (
      good_cnt >= 8'h01 |-> term_out[k] == term_want($past(output_terminal_select[k*8+:8]),
      $past(flg))) else $error("terminal does not follow its selected flag");
  end
  norun_track_a: assert property (
    two_good |-> speed_arrival_norun_flag == $past((diff <= hyst) && (diff >= -hyst), 2))
    else $error("norun arrival flag wrong");
  accel_on_a: assert property (three_good ##0 $past(diff > hyst, 3) |-> accelerating_flag)
    else $error("accelerating flag missing");
  accel_rise_a: assert property (
    three_good ##0 $rose(accelerating_flag) |-> $past(diff > hyst, 3))
    else $error("accelerating flag rose inside band");
  agree_on_a: assert property (
    three_good ##0 ($past(speed_agree_raw, 3) && $past(speed_agree_raw, 2)) |->
    speed_agreement_flag) else $error("agreement flag missing");
  thr_set_a: assert property (two_good ##0 $past(cmp > thr_hi, 2) |-> speed_threshold_flag_1)
    else $error("threshold flag not set");
  thr_clear_a: assert property (
    two_good ##0 $past(cmp < thr_lo, 2) |-> !speed_threshold_flag_1)
    else $error("threshold flag not cleared");
  cur_qual_a: assert property (
    $rose(current_detect_flag_1) |-> above_cnt >= $past(det_need))
    else $error("current flag set before qualify time");
  cur_width_a: assert property ($fell(current_detect_flag_1) |-> $past(on_cnt) >= 24'd98)
    else $error("current flag pulse too short");
  ot_excl_a: assert property (
    $past(protection_options_setting[0], 2) && $past(protection_options_setting[0]) |->
    !current_detect_flag_1) else $error("current flag on in over-torque mode");
endmodule // speed_current_detect_outputs_chk

bind speed_current_detect_outputs speed_current_detect_outputs_chk #(
  .SPW(SPW), .CW(CW), .NTERM(NTERM)) u_chk (.*);

// ---- verif/tb_top.sv ----
// testbench for the speed and current detect output block
// assumes smp every cycle (1 sample = 1 cycle), inputs driven at falling edge
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0, srst = 1'b1, ce = 1'b1, smp = 1'b1, run_cmd = 1'b0, tvc_mode = 1'b0;
  logic speed_agree_raw = 1'b0, direction_judge = 1'b0;
  logic signed [20:0] ref_speed_pre = '0, ref_speed_final = '0, det_speed = '0;
  logic [15:0] out_current = '0, rated_current = 16'h2710, arrival_off_delay_setting = '0;
  logic [15:0] current_level_1_setting = '0, current_level_2_setting = '0;
  logic [15:0] current_detect_time_setting = 16'h1;
  logic signed [8:0] torque_cmd = '0;
  logic [19:0] arrival_hysteresis_setting = 20'h3e8, speed_level_1_setting = 20'hfffff;
  logic [19:0] speed_level_2_setting = 20'hfffff, threshold_hysteresis_setting = '0;
  logic [6:0] direction_level_setting = '0;
  logic [7:0] protection_options_setting = '0;
  logic [47:0] output_terminal_select = 48'h1f024a494801;
  logic [5:0] term_out, term_seen;
  logic speed_arrival_flag, speed_arrival_norun_flag, accelerating_flag, decelerating_flag;
  logic speed_agreement_flag, speed_threshold_flag_1, speed_threshold_flag_2;
  logic current_detect_flag_1, current_detect_flag_2, over_torque_detect;
  logic recommended_direction_out;
  int errors = 0, cmp_count = 0, cycles = 0;
  always #25 sys_clk = ~sys_clk;
  speed_current_detect_outputs u_dut (.*);
  lift_ctrl_model u_lift (.sys_clk(sys_clk), .clr(srst), .term_out(term_out),
    .term_seen(term_seen));
  task results;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task t_arrival;
    run_cmd = 1'b1; ref_speed_pre = 21'h186a0; det_speed = 21'h182b8; cyc(6);
    chk(speed_arrival_flag === 1'b1 && term_out[0] === 1'b1, "arrival on");
    chk(speed_arrival_norun_flag === 1'b1 && term_out[1] === 1'b1, "norun on");
    run_cmd = 1'b0; cyc(6);
    chk(speed_arrival_flag === 1'b0 && speed_arrival_norun_flag === 1'b1, "run gate");
    run_cmd = 1'b1; ref_speed_pre = -21'sh186a0; det_speed = -21'sh186a0; cyc(6);
    chk(speed_arrival_flag === 1'b0, "negative ref");
    ref_speed_pre = 21'h186a0; ref_speed_final = 21'h186a0; det_speed = '0;
    tvc_mode = 1'b1; cyc(6);
    chk(speed_arrival_flag === 1'b1, "final ref used");
    tvc_mode = 1'b0; cyc(6);
    chk(speed_arrival_norun_flag === 1'b0, "detected speed used");
  endtask
  task t_accel;
    det_speed = 21'hc350; cyc(6);
    chk(accelerating_flag === 1'b1 && decelerating_flag === 1'b0 && term_out[2] === 1'b1,
      "accel");
    arrival_off_delay_setting = 16'h1; det_speed = 21'h182b8; cyc(5);
    chk(accelerating_flag === 1'b1, "off delay holds");
    cyc(15);
    chk(accelerating_flag === 1'b0, "accel off in band");
    ref_speed_pre = '0; speed_agree_raw = 1'b1; cyc(6);
    chk(decelerating_flag === 1'b1 && term_out[3] === 1'b1, "decel");
    chk(speed_agreement_flag === 1'b1, "agreement on");
    speed_agree_raw = 1'b0; cyc(5);
    chk(speed_agreement_flag === 1'b1, "agreement delayed off");
  endtask
  task t_thresh;
    speed_level_1_setting = 20'h493e0; threshold_hysteresis_setting = 20'h2710;
    det_speed = 21'h493e1; cyc(4);
    chk(speed_threshold_flag_1 === 1'b1 && term_out[4] === 1'b1, "thr set");
    det_speed = 21'h48058; cyc(4);
    chk(speed_threshold_flag_1 === 1'b1, "thr hold");
    det_speed = 21'h46ccf; cyc(4);
    chk(speed_threshold_flag_1 === 1'b0, "thr clear");
    det_speed = 21'h9eb10; cyc(4);
    chk(speed_threshold_flag_2 === 1'b1 && term_out[5] === 1'b1, "thr2 clamped");
    chk(term_seen === 6'h3f, "controller saw every terminal");
  endtask
  task t_current;
    output_terminal_select = 48'h000000ff2625; current_level_1_setting = 16'h1388;
    out_current = 16'h1770; cyc(8);
    chk(current_detect_flag_1 === 1'b0, "qualify wait");
    cyc(12);
    chk(current_detect_flag_1 === 1'b1 && term_out[0] === 1'b1, "cur set");
    chk(current_detect_flag_2 === 1'b0 && term_out[2] === 1'b0, "disabled, unknown");
    out_current = 16'h11f8; cyc(150);
    chk(current_detect_flag_1 === 1'b1, "above drop level");
    out_current = 16'h1130; cyc(8);
    chk(current_detect_flag_1 === 1'b0, "drop out");
    out_current = 16'h1770; cyc(14);
    out_current = '0; cyc(40);
    chk(current_detect_flag_1 === 1'b1, "min width");
    cyc(80);
    chk(current_detect_flag_1 === 1'b0, "width end");
    protection_options_setting = 8'h01; out_current = 16'h1770; cyc(20);
    chk(over_torque_detect === 1'b1 && current_detect_flag_1 === 1'b0, "over torque");
  endtask
  task t_dir;
    direction_level_setting = 7'h14; direction_judge = 1'b1; torque_cmd = -9'sh1e; cyc(4);
    chk(recommended_direction_out === 1'b1, "forward");
    torque_cmd = 9'sh0a; cyc(4);
    chk(recommended_direction_out === 1'b1, "inside level holds");
    torque_cmd = 9'sh1e; cyc(4);
    chk(recommended_direction_out === 1'b0, "reverse");
    ce = 1'b0; torque_cmd = -9'sh1e; cyc(4);
    chk(recommended_direction_out === 1'b0, "frozen by ce");
    ce = 1'b1; cyc(4);
    chk(recommended_direction_out === 1'b1, "forward after ce");
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end
  initial begin
    cyc(2);
    srst = 1'b0;
    cyc(1);
    chk(term_out === 6'h00 && speed_arrival_flag === 1'b0, "reset values");
    t_arrival();
    t_accel();
    t_thresh();
    t_current();
    t_dir();
    results();
  end
endmodule // tb_top
